//--- rtl/mfb_top.sv
// motion detection function block: sectors, brightness, detection states, outputs
//
// Contract
// RULE1 - auto-on/manual-off: motion starts, no run-on, only manual OFF ends
// RULE2 - auto-on/manual-off mode refused for presence-detector-light-control application
// RULE3 - two outputs per block; output with no function sends nothing
// RULE4 - switching output sends single-bit ON/OFF
// RULE5 - staircase output repeats single-bit ON while detection active
// RULE6 - forced-position output sends two-bit priority telegrams
// RULE7 - dimming output sends one-byte scaled percentage 0 to 100
// RULE8 - scene output sends one-byte scene number 1 to 64
// RULE9 - temperature output sends two-byte float, 0 to 40 degrees
// RULE10 - brightness output sends two-byte float, 0 to 2000 lux by 50
// RULE11 - controller-mode output sends one-byte room controller mode
// RULE12 - extension role has no outputs; simple detector uses output 1 switching
// RULE13 - three PIR sectors, each separately assigned to the block
// RULE14 - assigned sector motions are ORed into one motion signal
// RULE15 - brightness from internal, external or weighted combination
// RULE16 - external sources: brightness-independent until first external value
// RULE17 - combined source with one value present uses that value unweighted
// RULE18 - brightness-independent: any motion while idle starts detection; in MD_SEMI1 mode the code starts only on man_on
// RULE19 - brightness-dependent: motion accepted only below twilight threshold
// RULE20 - simple detector application always brightness-independent
// RULE21 - presence detector lit above switch-off level ignores motion, runs out
// RULE22 - manual OFF while active cancels, sends end telegrams, returns idle
// RULE23 - twilight threshold register compared each cycle with effective brightness
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "mfb_defines.svh"
module mfb_top
   import mfb_pkg::*;
#(
   parameter int TICK_CYC = `MFB_TICK_CYC
)(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                ce,
   input  wire logic [7:0]          addr,
   input  wire logic [31:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic [31:0]              rdata,
   input  wire logic [2:0]          pir_sector,
   input  wire logic                ext_motion,
   input  wire logic                man_on,
   input  wire logic                man_off,
   input  wire logic [15:0]         ext_bright,
   input  wire logic                ext_bright_stb,
   input  wire logic [15:0]         int_bright,
   input  wire logic                int_bright_ok,
   output logic [1:0]               tx_stb,
   output logic [1:0][1:0]          tx_len,
   output logic [1:0][15:0]         tx_data,
   output logic                     detecting
);
   // ******************************************
   // state and decoded configuration
   // ******************************************
   localparam logic [23:0] TICK_LAST = 24'(TICK_CYC - 1);

   mfb_st_t     st;
   mfb_st_t     next_st;
   mfb_app_t    app;
   mfb_mode_t   mode;
   mfb_src_t    src;
   logic [4:0]  w_int;
   logic [4:0]  w_ext;
   logic [20:0] wsum;
   logic [15:0] eff;
   logic        eff_ok;
   logic        dep_eff;
   logic        motion;
   logic        bright_high;
   logic        accept;
   logic        active;
   logic        tick_p;
   logic        expire;
   logic        start_ev;
   logic        end_ev;
   logic        stair_ev;
   logic        dep_mode;
   mfb_func_t   func_eff [2];
   logic        enc_send [2];
   mfb_len_t    enc_len [2];
   logic [15:0] enc_pay [2];

   assign app    = mfb_app_t'(st.ctrl[`MFB_F_APP]);
   assign mode   = mfb_mode_t'(st.ctrl[`MFB_F_MODE]);
   assign src    = mfb_src_t'(st.ctrl[`MFB_F_SRC]);
   assign active = (st.fsm == S_ACTIVE);

   // ******************************************
   // brightness source and evaluation
   // ******************************************
   assign w_int = {1'b0, st.ctrl[`MFB_F_WGT]};
   assign w_ext = `MFB_WGT_FULL - w_int;
   assign wsum  = 21'(int_bright * w_int) + 21'(st.ext_b * w_ext);

   always_comb begin
      eff    = int_bright;
      eff_ok = int_bright_ok;
      unique case (src)
         SRC_INT: begin
            eff    = int_bright;
            eff_ok = int_bright_ok;
         end
         SRC_EXT: begin
            eff    = st.ext_b;
            eff_ok = st.ext_ok;
         end
         SRC_BOTH: begin
            eff_ok = int_bright_ok | st.ext_ok;
            if (int_bright_ok && st.ext_ok) begin
               eff = wsum[19:4]; // RULE15
            end else if (st.ext_ok) begin
               eff = st.ext_b; // RULE17
            end else begin
               eff = int_bright; // RULE17
            end
         end
         default: begin
            eff    = 16'h0000;
            eff_ok = 1'b0;
         end
      endcase
   end

   // independent for detector and light-control application, and until valid values
   assign dep_mode = st.ctrl[`MFB_F_DEP] && app != APP_DET && app != APP_PLC; // RULE20
   assign dep_eff  = dep_mode && eff_ok && (src == SRC_INT || st.ext_ok); // RULE16

   // ******************************************
   // motion combination and acceptance
   // ******************************************
   assign motion = |(st.s2 & st.ctrl[`MFB_F_SEL]) | ext_motion; // RULE13 RULE14
   assign bright_high = dep_eff && app == APP_PRES && active &&
                        {1'b0, eff} > {st.thr, 1'b0}; // RULE21
   assign accept = motion && !bright_high &&
                   (!dep_eff || eff < st.thr); // RULE18 RULE19 RULE23

   // ******************************************
   // detection events
   // ******************************************
   assign tick_p   = (st.tick == TICK_LAST);
   assign expire   = active && mode != MD_AOMO && st.runon == 16'h0000; // RULE1
   assign end_ev   = active && (man_off || expire); // RULE22
   assign start_ev = !active && (mode == MD_SEMI1 ? man_on : (accept || man_on));
   assign stair_ev = active && !end_ev && tick_p && st.stair == 16'h0000;

   // ******************************************
   // output encoders
   // ******************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_out
         mfb_enc_if eif ();
         always_comb begin
            if (st.ctrl[`MFB_F_EXT]) begin
               func_eff[gi] = FN_NONE; // RULE12
            end else if (app == APP_DET) begin
               func_eff[gi] = (gi == 0) ? FN_SW : FN_NONE; // RULE12
            end else begin
               func_eff[gi] = mfb_func_t'(st.outc[4*gi +: 4]); // RULE3
            end
         end
         assign eif.func     = func_eff[gi];
         assign eif.val      = st.outc[8 + 8*gi +: 8];
         assign eif.start    = !end_ev;
         assign enc_send[gi] = eif.send;
         assign enc_len[gi]  = eif.len;
         assign enc_pay[gi]  = eif.payload;
         mfb_enc u_enc (
            .e (eif.enc)
         );
      end
   endgenerate

   // ******************************************
   // next state
   // ******************************************
   always_comb begin
      next_st        = st;
      next_st.s1     = pir_sector;
      next_st.s2     = st.s1;
      next_st.tx_stb = 2'b00;
      next_st.rdata  = 32'h0000_0000;
      next_st.tick   = tick_p ? 24'h00_0000 : st.tick + 24'h00_0001;

      if (wr) begin
         unique case (addr)
            `MFB_A_CTRL: begin
               next_st.ctrl = wdata;
               if (mfb_app_t'(wdata[`MFB_F_APP]) == APP_PLC &&
                   mfb_mode_t'(wdata[`MFB_F_MODE]) == MD_AOMO) begin
                  next_st.ctrl[`MFB_F_MODE] = MD_AUTO; // RULE2
               end
            end
            `MFB_A_OUT:  next_st.outc = wdata;
            `MFB_A_THR:  next_st.thr  = wdata[15:0]; // RULE23
            `MFB_A_TIME: next_st.tim  = wdata;
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            `MFB_A_CTRL: next_st.rdata = st.ctrl;
            `MFB_A_OUT:  next_st.rdata = st.outc;
            `MFB_A_THR:  next_st.rdata = {16'h0000, st.thr};
            `MFB_A_TIME: next_st.rdata = st.tim;
            `MFB_A_STAT: next_st.rdata = {eff, 12'h000, bright_high, dep_eff,
                                          st.ext_ok, st.det};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end

      if (ext_bright_stb) begin
         next_st.ext_b  = ext_bright;
         next_st.ext_ok = 1'b1;
      end

      unique case (st.fsm)
         S_IDLE: begin
            if (start_ev) begin
               next_st.fsm   = S_ACTIVE;
               next_st.runon = st.tim[`MFB_F_RUNON];
               next_st.stair = st.tim[`MFB_F_STAIR];
            end
         end
         S_ACTIVE: begin
            if (end_ev) begin
               next_st.fsm = S_IDLE; // RULE1 RULE22
            end else begin
               if (accept && mode != MD_AOMO) begin
                  next_st.runon = st.tim[`MFB_F_RUNON];
               end else if (tick_p && st.runon != 16'h0000) begin
                  next_st.runon = st.runon - 16'h0001;
               end
               if (tick_p) begin
                  next_st.stair = (st.stair == 16'h0000) ? st.tim[`MFB_F_STAIR]
                                                         : st.stair - 16'h0001;
               end
            end
         end
      endcase
      next_st.det = (next_st.fsm == S_ACTIVE);

      for (int i = 0; i < 2; i++) begin
         if ((start_ev || end_ev || (stair_ev && func_eff[i] == FN_STAIR)) &&
             enc_send[i]) begin
            next_st.tx_stb[i]  = 1'b1; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11
            next_st.tx_len[i]  = enc_len[i];
            next_st.tx_data[i] = enc_pay[i];
         end
      end
   end

   // ******************************************
   // registers
   // ******************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st      <= '0;
         st.ctrl <= `MFB_CTRL_RST;
         st.outc <= `MFB_OUT_RST;
         st.thr  <= `MFB_THR_RST;
         st.tim  <= `MFB_TIME_RST;
         st.fsm  <= S_IDLE;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdata     = st.rdata;
   assign tx_stb    = st.tx_stb;
   assign tx_len    = st.tx_len;
   assign tx_data   = st.tx_data;
   assign detecting = st.det;

   // ******************************************
   // assertions
   // ******************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_aomo_hold;
      ce && active && mode == MD_AOMO && !man_off |=> active;
   endproperty
   a_aomo_hold: assert property (p_aomo_hold) else $error("manual-off mode ended alone"); // RULE1

   property p_no_plc_aomo;
      app == APP_PLC |-> mode != MD_AOMO;
   endproperty
   a_no_plc_aomo: assert property (p_no_plc_aomo) else $error("illegal mode kept"); // RULE2

   property p_none_silent;
      ce && func_eff[0] == FN_NONE |=> !st.tx_stb[0];
   endproperty
   a_none_silent: assert property (p_none_silent) else $error("unused output sent"); // RULE3

   property p_sw_len;
      ce && func_eff[0] == FN_SW && (start_ev || end_ev)
         |=> st.tx_stb[0] && st.tx_len[0] == LEN_1B && st.tx_data[0] == {15'h0000, active};
   endproperty
   a_sw_len: assert property (p_sw_len) else $error("bad switch telegram"); // RULE4

   property p_ext_role;
      ce && st.ctrl[`MFB_F_EXT] |=> st.tx_stb == 2'b00;
   endproperty
   a_ext_role: assert property (p_ext_role) else $error("extension sent telegram"); // RULE12

   sequence s_sector_b;
      (ce && st.ctrl[9] && pir_sector[1] && !wr) [*3];
   endsequence
   property p_sector_or;
      s_sector_b |-> motion;
   endproperty
   a_sector_or: assert property (p_sector_or) else $error("sector motion lost"); // RULE14

   property p_ext_wait;
      ce && !active && mode != MD_SEMI1 && motion && src != SRC_INT && !st.ext_ok
         |=> st.det;
   endproperty
   a_ext_wait: assert property (p_ext_wait) else $error("dependent before ext value"); // RULE16

   property p_one_src;
      src == SRC_BOTH && (int_bright_ok ^ st.ext_ok)
         |-> eff == (st.ext_ok ? st.ext_b : int_bright);
   endproperty
   a_one_src: assert property (p_one_src) else $error("single source weighted"); // RULE17

   property p_dep_start;
      ce && !active && mode != MD_SEMI1 && accept && dep_eff |-> eff < st.thr ##1 st.det;
   endproperty
   a_dep_start: assert property (p_dep_start) else $error("dependent start above level"); // RULE19

   sequence s_off_req;
      ce && active && man_off;
   endsequence
   property p_man_off;
      s_off_req |=> !st.det && st.tx_stb[0] == $past(enc_send[0]);
   endproperty
   a_man_off: assert property (p_man_off) else $error("manual off not honoured"); // RULE22
endmodule

//--- rtl/mfb_defines.svh
// register map, field positions, reset values and timing counts of the motion block
`ifndef MFB_DEFINES_SVH
`define MFB_DEFINES_SVH
`define MFB_A_CTRL   8'h00
`define MFB_A_OUT    8'h04
`define MFB_A_THR    8'h08
`define MFB_A_TIME   8'h0C
`define MFB_A_STAT   8'h10
`define MFB_F_APP    1:0
`define MFB_F_EXT    2
`define MFB_F_MODE   4:3
`define MFB_F_DEP    5
`define MFB_F_SRC    7:6
`define MFB_F_SEL    10:8
`define MFB_F_WGT    14:11
`define MFB_F_RUNON  15:0
`define MFB_F_STAIR  31:16
`define MFB_CTRL_RST 32'h0000_4721
`define MFB_OUT_RST  32'h0000_6401
`define MFB_THR_RST  16'h00C8
`define MFB_TIME_RST 32'h000A_003C
`define MFB_WGT_FULL 5'h10
`define MFB_PCT_MAX  8'h64
`define MFB_SCN_MAX  8'h40
`define MFB_TMP_MAX  8'h28
`define MFB_LUX_STEP 12'h032
`define MFB_LUX_MAX  12'h7D0
`define MFB_MOD_MAX  8'h04
`define MFB_CENTI    18'h00064
`define MFB_MANT_MAX 18'h007FF
`define MFB_CLK_NS   100
`define MFB_TICK_MS  1000
`define MFB_TICK_CYC (`MFB_TICK_MS * 1000000 / `MFB_CLK_NS)
`endif

//--- rtl/mfb_pkg.sv
// types shared by the motion block modules
package mfb_pkg;
   typedef enum logic [1:0] {APP_DET, APP_CEIL, APP_PRES, APP_PLC} mfb_app_t;
   typedef enum logic [1:0] {MD_AUTO, MD_SEMI1, MD_AOMO, MD_RSV} mfb_mode_t;
   typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_BOTH, SRC_RSV} mfb_src_t;
   typedef enum logic [1:0] {LEN_1B, LEN_2B, LEN_BYTE, LEN_WORD} mfb_len_t;
   typedef enum logic [3:0] {FN_NONE, FN_SW, FN_STAIR, FN_FORCE, FN_DIM, FN_SCENE,
                             FN_TEMP, FN_LUX, FN_MODE} mfb_func_t;
   typedef enum logic {S_IDLE, S_ACTIVE} mfb_fsm_t;
   typedef struct packed {
      logic [31:0]        ctrl;
      logic [31:0]        outc;
      logic [15:0]        thr;
      logic [31:0]        tim;
      logic [2:0]         s1;
      logic [2:0]         s2;
      logic               ext_ok;
      logic [15:0]        ext_b;
      logic [23:0]        tick;
      logic [15:0]        runon;
      logic [15:0]        stair;
      mfb_fsm_t           fsm;
      logic               det;
      logic [31:0]        rdata;
      logic [1:0]         tx_stb;
      mfb_len_t [1:0]     tx_len;
      logic [1:0][15:0]   tx_data;
   } mfb_st_t;
endpackage

//--- rtl/mfb_enc_if.sv
// link between the detection core and one telegram encoder
`timescale 1ns/100ps
interface mfb_enc_if;
   import mfb_pkg::*;
   mfb_func_t   func;
   logic [7:0]  val;
   logic        start;
   logic        send;
   mfb_len_t    len;
   logic [15:0] payload;
   modport core (output func, val, start, input send, len, payload);
   modport enc  (input func, val, start, output send, len, payload);
endinterface

//--- rtl/mfb_enc.sv
// telegram encoder for one output of the motion block
`timescale 1ns/100ps
`include "mfb_defines.svh"
module mfb_enc
   import mfb_pkg::*;
(
   mfb_enc_if.enc e
);
   function automatic logic [15:0] to_float(input logic [17:0] c);
      logic [17:0] m;
      logic [3:0]  ex;
      m  = c;
      ex = 4'h0;
      for (int k = 0; k < 8; k++) begin
         if (m > `MFB_MANT_MAX) begin
            m  = m >> 1;
            ex = ex + 4'h1;
         end
      end
      return {1'b0, ex, m[10:0]};
   endfunction

   logic [7:0]  pct;
   logic [15:0] dimv;
   logic [7:0]  scn;
   logic [7:0]  tmp;
   logic [11:0] lux;

   always_comb begin
      pct  = (e.val > `MFB_PCT_MAX) ? `MFB_PCT_MAX : e.val;
      dimv = 16'((pct * 16'h00FF) / 16'h0064);
      scn  = (e.val == 8'h00) ? 8'h01 : ((e.val > `MFB_SCN_MAX) ? `MFB_SCN_MAX : e.val);
      tmp  = (e.val > `MFB_TMP_MAX) ? `MFB_TMP_MAX : e.val;
      lux  = 12'(e.val * `MFB_LUX_STEP);
      if (lux > `MFB_LUX_MAX) begin
         lux = `MFB_LUX_MAX;
      end
      e.send    = 1'b1;
      e.len     = LEN_1B;
      e.payload = 16'h0000;
      unique case (e.func)
         FN_NONE: begin
            e.send = 1'b0; // RULE3
         end
         FN_SW, FN_STAIR: begin
            e.payload = {15'h0000, e.start}; // RULE4 RULE5
         end
         FN_FORCE: begin
            e.len     = LEN_2B;
            e.payload = {14'h0000, 1'b1, e.start}; // RULE6
         end
         FN_DIM: begin
            e.len     = LEN_BYTE;
            e.payload = e.start ? dimv : 16'h0000; // RULE7
         end
         FN_SCENE: begin
            e.send    = e.start;
            e.len     = LEN_BYTE;
            e.payload = {8'h00, 8'(scn - 8'h01)}; // RULE8
         end
         FN_TEMP: begin
            e.send    = e.start;
            e.len     = LEN_WORD;
            e.payload = to_float(18'(tmp * `MFB_CENTI)); // RULE9
         end
         FN_LUX: begin
            e.send    = e.start;
            e.len     = LEN_WORD;
            e.payload = to_float(18'(lux * `MFB_CENTI)); // RULE10
         end
         FN_MODE: begin
            e.send    = e.start;
            e.len     = LEN_BYTE;
            e.payload = {8'h00, (e.val > `MFB_MOD_MAX) ? `MFB_MOD_MAX : e.val}; // RULE11
         end
         default: begin
            e.send = 1'b0;
         end
      endcase
   end
endmodule

//--- tb/mfb_bus_model.sv
// far-side model: bus sensors and actuators exchanging group telegrams
`timescale 1ns/100ps
module mfb_bus_model (
   input  wire logic             clk,
   output logic                  ext_motion,
   output logic                  man_on,
   output logic                  man_off,
   output logic [15:0]           ext_bright,
   output logic                  ext_bright_stb,
   input  wire logic [1:0]       tx_stb,
   input  wire logic [1:0][1:0]  tx_len,
   input  wire logic [1:0][15:0] tx_data
);
   int          cnt [2] = '{0, 0};
   logic [1:0]  last_len [2];
   logic [15:0] last_data [2];

   initial begin
      ext_motion = 1'b0;
      man_on = 1'b0;
      man_off = 1'b0;
      ext_bright = 16'h0000;
      ext_bright_stb = 1'b0;
   end

   // ********************************
   // one telegram pulse: k = {on, bright, off, motion}
   // ********************************
   task automatic send(input logic [3:0] k, input logic [15:0] lux);
      @(posedge clk);
      ext_motion <= k[0];
      man_off <= k[1];
      ext_bright_stb <= k[2];
      man_on <= k[3];
      ext_bright <= lux;
      @(posedge clk);
      ext_motion <= 1'b0;
      man_off <= 1'b0;
      ext_bright_stb <= 1'b0;
      man_on <= 1'b0;
      // stale value must not look valid
      ext_bright <= ~lux;
   endtask

   // actuators log what arrives on each output
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (tx_stb[i] === 1'b1) begin
            cnt[i] <= cnt[i] + 1;
            last_len[i] <= tx_len[i];
            last_data[i] <= tx_data[i];
         end
      end
   end
endmodule

//--- tb/mfb_top_test.sv
// self-checking bench of the motion function block
`timescale 1ns/100ps
module mfb_top_test
   import mfb_pkg::*;
;
   logic             clk = 1'b0;
   logic             nrst = 1'b0;
   logic             ce = 1'b1;
   logic [7:0]       addr = 8'h00;
   logic [31:0]      wdata = 32'h0000_0000;
   logic             wr = 1'b0;
   logic             rd = 1'b0;
   logic [31:0]      rdata;
   logic [2:0]       pir_sector = 3'h0;
   logic             ext_motion;
   logic             man_on;
   logic             man_off;
   logic [15:0]      ext_bright;
   logic             ext_bright_stb;
   logic [15:0]      int_bright = 16'h0000;
   logic             int_bright_ok = 1'b0;
   logic [1:0]       tx_stb;
   logic [1:0][1:0]  tx_len;
   logic [1:0][15:0] tx_data;
   logic             detecting;
   int               num_errors = 0;
   int               checks = 0;
   int               cyc = 0;
   int               n;
   int               m;
   mfb_func_t        fn_t [8] = '{FN_SW, FN_STAIR, FN_FORCE, FN_DIM, FN_SCENE, FN_TEMP,
                                  FN_LUX, FN_MODE};
   logic [7:0]       vl_t [8] = '{8'h00, 8'h00, 8'h00, 8'h32, 8'h0A, 8'h15, 8'h04, 8'h02};
   mfb_len_t         ln_t [8] = '{LEN_1B, LEN_1B, LEN_2B, LEN_BYTE, LEN_BYTE, LEN_WORD,
                                  LEN_WORD, LEN_BYTE};
   logic [15:0]      dt_t [8] = '{16'h0001, 16'h0001, 16'h0003, 16'h007F, 16'h0009,
                                  16'h0C1A, 16'h24E2, 16'h0002};

   always #50 clk = ~clk;

   mfb_top #(.TICK_CYC(4)) u_mfb_top (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pir_sector(pir_sector),
      .ext_motion(ext_motion), .man_on(man_on), .man_off(man_off),
      .ext_bright(ext_bright), .ext_bright_stb(ext_bright_stb), .int_bright(int_bright),
      .int_bright_ok(int_bright_ok), .tx_stb(tx_stb), .tx_len(tx_len),
      .tx_data(tx_data), .detecting(detecting));

   mfb_bus_model u_mfb_bus_model (.clk(clk), .ext_motion(ext_motion), .man_on(man_on),
      .man_off(man_off), .ext_bright(ext_bright), .ext_bright_stb(ext_bright_stb),
      .tx_stb(tx_stb), .tx_len(tx_len), .tx_data(tx_data));

   // ********************************
   // access and compare tasks
   // ********************************
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] msk,
                         input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, rdata & msk, e);
   endtask

   task automatic det(input logic e);
      settle(3);
      chk("detecting", {31'h0, detecting}, {31'h0, e});
   endtask

   task automatic motion();
      u_mfb_bus_model.send(4'b0001, 16'h0000);
   endtask

   task automatic off();
      u_mfb_bus_model.send(4'b0010, 16'h0000);
      settle(3);
   endtask

   task automatic sector(input logic [2:0] s);
      @(posedge clk);
      pir_sector <= s;
      settle(3);
      @(posedge clk);
      pir_sector <= 3'h0;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   // ********************************
   // test sequence
   // ********************************
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd_chk("ctrl rst", 8'h00, 32'hFFFF_FFFF, 32'h0000_4721);
      rd_chk("out rst", 8'h04, 32'hFFFF_FFFF, 32'h0000_6401);
      rd_chk("thr rst", 8'h08, 32'hFFFF_FFFF, 32'h0000_00C8);
      rd_chk("time rst", 8'h0C, 32'hFFFF_FFFF, 32'h000A_003C);
      rd_chk("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
      wr_reg(8'h00, 32'h0000_4713);
      rd_chk("plc mode", 8'h00, 32'hFFFF_FFFF, 32'h0000_4703);
      // external source, dependent, before any external value
      @(posedge clk);
      int_bright <= 16'h012C;
      int_bright_ok <= 1'b1;
      wr_reg(8'h00, 32'h0000_4771);
      motion();
      det(1'b1);
      off();
      u_mfb_bus_model.send(4'b0100, 16'h01F4);
      motion();
      det(1'b0);
      u_mfb_bus_model.send(4'b0100, 16'h0064);
      motion();
      det(1'b1);
      off();
      // combined source
      @(posedge clk);
      int_bright_ok <= 1'b0;
      wr_reg(8'h00, 32'h0000_4791);
      rd_chk("eff single", 8'h10, 32'hFFFF_0000, 32'h0064_0000);
      @(posedge clk);
      int_bright_ok <= 1'b1;
      rd_chk("eff weighted", 8'h10, 32'hFFFF_0000, 32'h00C8_0000);
      // internal source against a moved threshold
      wr_reg(8'h00, 32'h0000_4731);
      motion();
      det(1'b0);
      wr_reg(8'h08, 32'h0000_0190);
      motion();
      det(1'b1);
      off();
      // sector B only, auto-on/manual-off
      wr_reg(8'h00, 32'h0000_4211);
      sector(3'b001);
      det(1'b0);
      sector(3'b010);
      det(1'b1);
      chk("out1 len", {30'h0, u_mfb_bus_model.last_len[0]}, {30'h0, LEN_1B});
      chk("out1 on", {16'h0, u_mfb_bus_model.last_data[0]}, 32'h1);
      settle(300);
      chk("no runon", {31'h0, detecting}, 32'h1);
      chk("out2 none", u_mfb_bus_model.cnt[1], 0);
      off();
      chk("end det", {31'h0, detecting}, 32'h0);
      chk("out1 off", {16'h0, u_mfb_bus_model.last_data[0]}, 32'h0);
      motion();
      det(1'b1);
      off();
      // every output function on output 2
      wr_reg(8'h00, 32'h0000_4711);
      for (int i = 0; i < 8; i++) begin
         wr_reg(8'h04, {8'h00, vl_t[i], 8'h64, fn_t[i], 4'h1});
         n = u_mfb_bus_model.cnt[1];
         motion();
         settle(3);
         chk("out2 len", {30'h0, u_mfb_bus_model.last_len[1]}, {30'h0, ln_t[i]});
         chk("out2 data", {16'h0, u_mfb_bus_model.last_data[1]}, {16'h0, dt_t[i]});
         if (fn_t[i] == FN_STAIR) begin
            settle(60);
            chk("stair repeat", u_mfb_bus_model.cnt[1] - n > 1, 32'h1);
         end
         off();
      end
      // simple detector and extension role
      wr_reg(8'h04, 32'h0000_6441);
      int_bright <= 16'h01F4;
      wr_reg(8'h00, 32'h0000_4720);
      n = u_mfb_bus_model.cnt[1];
      motion();
      det(1'b1);
      chk("simple out2", u_mfb_bus_model.cnt[1], n);
      off();
      wr_reg(8'h00, 32'h0000_4715);
      n = u_mfb_bus_model.cnt[0];
      m = u_mfb_bus_model.cnt[1];
      motion();
      settle(3);
      chk("ext role", u_mfb_bus_model.cnt[0] + u_mfb_bus_model.cnt[1], n + m);
      off();
      // presence app: bright room ends detection despite motion
      wr_reg(8'h08, 32'h0000_00C8);
      wr_reg(8'h0C, 32'h000A_0005);
      wr_reg(8'h00, 32'h0000_4722);
      int_bright <= 16'h0064;
      motion();
      det(1'b1);
      @(posedge clk);
      int_bright <= 16'h01F4;
      rd_chk("above off", 8'h10, 32'h0000_0008, 32'h0000_0008);
      repeat (5) begin
         motion();
         settle(8);
      end
      chk("lit ends", {31'h0, detecting}, 32'h0);
      chk("lit off tel", {16'h0, u_mfb_bus_model.last_data[0]}, 32'h0);
      give_verdict();
   end
endmodule
